/* File: verilog/flash_block_protection_timing.sv */
// flash controller: protection check, program/erase/commit sequencing
`timescale 1ns/100ps
// Function
// RQ1: flash is erased in independent 1 KB units.
// RQ2: erasing a unit sets every bit in it to one.
// RQ3: programming writes one 32-bit word and can only clear bits.
// RQ4: protection applies per 2 KB block, two adjacent erase units each.
// RQ5: program and read permits are 32-bit registers, one bit per block.
// RQ6: program permit one allows program/erase; zero refuses any change.
// RQ7: read permit one allows data reads; zero leaves only fetches.
// RQ8: program one, read zero: write, erase, execute yes, data read no.
// RQ9: execute-only blocks refuse every data read, literal loads included.
// RQ10: data read of read-protected block is refused with a bus fault.
// RQ11: refused program/erase sets access flag; interrupt only when masked in.
// RQ12: both permit registers read all ones as delivered.
// RQ13: permit writes can only clear bits, never set them back.
// RQ14: uncommitted cleared permit bits return to committed value on reset.
// RQ15: a commit command makes current permit changes non-volatile.
// RQ16: program/erase timing derives from cycles-per-microsecond reload.
// RQ17: reload resets to a value safe at highest clock rate.
// RQ18: software loads MHz minus one into reload before modifying flash.
// RQ19: software sets address bit 0 to pick program or read permit commit.
// RQ20: writing one to an interrupt clear bit clears raw and masked status.
// RQ21: protection block index is the flash address divided by 2048.
// RQ22: commit busy stays high until the non-volatile update ends.
module flash_block_protection_timing #(
    parameter int PROG_TIME_US = flash_prot_pkg::PROG_TIME_US,
    parameter int ERASE_TIME_US = flash_prot_pkg::ERASE_TIME_US,
    parameter int COMMIT_TIME_US = flash_prot_pkg::COMMIT_TIME_US
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic nv_factory_rst,
    input wire logic ifetch_req,
    input wire logic [14:0] ifetch_addr,
    output logic [31:0] ifetch_rdata,
    output logic ifetch_valid,
    input wire logic dread_req,
    input wire logic [14:0] dread_addr,
    output logic [31:0] dread_rdata,
    output logic dread_valid,
    output logic dread_fault,
    input wire logic [14:0] flash_addr_reg,
    input wire logic [31:0] flash_wdata,
    input wire logic cmd_program,
    input wire logic cmd_erase,
    input wire logic cmd_commit,
    input wire logic ppermit_wr,
    input wire logic [31:0] ppermit_wdata,
    input wire logic rpermit_wr,
    input wire logic [31:0] rpermit_wdata,
    input wire logic reload_wr,
    input wire logic [7:0] reload_wdata,
    input wire logic access_fault_irq_mask,
    input wire logic irq_clr_access,
    input wire logic irq_clr_done,
    output logic [31:0] block_program_permit_bits,
    output logic [31:0] block_read_permit_bits,
    output logic [7:0] microsecond_tick_reload,
    output logic flash_busy,
    output logic commit_busy,
    output logic raw_access_irq,
    output logic raw_done_irq,
    output logic access_irq
);
    localparam int AW = flash_prot_pkg::ADDR_W;
    localparam int WW = flash_prot_pkg::WIDX_W;
    localparam int UW = flash_prot_pkg::US_W;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_LOAD = 5'h01,
        ST_IDLE = 5'h02,
        ST_PROG = 5'h04,
        ST_ERASE = 5'h08,
        ST_COMMIT = 5'h10
    } ctl_state_e;

    typedef struct packed {
        ctl_state_e st;
        logic [31:0] pp;
        logic [31:0] rp;
        logic [7:0] reload;
        logic [WW-1:0] widx;
        logic [31:0] wdata;
        logic commit_pp;
        logic raw_acc;
        logic raw_done;
        logic irq;
        logic dvalid;
        logic dfault;
        logic ivalid;
        logic busy;
        logic cbusy;
    } ctl_s;

    ctl_s r_ff;
    ctl_s nxt_r;

    logic t_start;
    logic [UW-1:0] t_dur;
    logic t_done;
    logic d_ok;
    logic prog_we;
    logic erase_we;
    logic nvpp_we;
    logic nvrp_we;
    logic [31:0] nv_pp;
    logic [31:0] nv_rp;
    logic acc_set;
    logic done_set;

    // block index: byte address divided by 2048
    function automatic logic [flash_prot_pkg::PBLK_W-1:0] pblk_of(
        input logic [14:0] a
    );
        pblk_of = a[AW-1:flash_prot_pkg::PBLK_LSB]; // [RQ21] [RQ4]
    endfunction

    // ****************************************************************
    // read path: fetches never checked, data reads gated by read permit
    // ****************************************************************
    assign d_ok = dread_req && r_ff.rp[pblk_of(dread_addr)]; // [RQ7] [RQ9]

    // ****************************************************************
    // sequencing
    // ****************************************************************
    always_comb begin
        nxt_r = r_ff;
        t_start = 1'b0;
        t_dur = UW'(PROG_TIME_US);
        prog_we = 1'b0;
        erase_we = 1'b0;
        nvpp_we = 1'b0;
        nvrp_we = 1'b0;
        acc_set = 1'b0;
        done_set = 1'b0;
        nxt_r.ivalid = ifetch_req;
        nxt_r.dvalid = d_ok;
        nxt_r.dfault = dread_req && !d_ok; // [RQ10] [RQ8]
        if (reload_wr) begin
            nxt_r.reload = reload_wdata;
        end
        if (ppermit_wr) begin
            nxt_r.pp = r_ff.pp & ppermit_wdata; // [RQ13] [RQ5]
        end
        if (rpermit_wr) begin
            nxt_r.rp = r_ff.rp & rpermit_wdata; // [RQ13] [RQ5]
        end
        case (r_ff.st)
            ST_LOAD: begin
                // working copies reload from the committed store
                nxt_r.pp = nv_pp; // [RQ14] [RQ12]
                nxt_r.rp = nv_rp; // [RQ14] [RQ12]
                nxt_r.st = ST_IDLE;
            end
            ST_IDLE: begin
                nxt_r.widx = flash_addr_reg[AW-1:2];
                nxt_r.wdata = flash_wdata;
                if (cmd_commit) begin
                    nxt_r.commit_pp = flash_addr_reg[0]; // [RQ19]
                    t_start = 1'b1;
                    t_dur = UW'(COMMIT_TIME_US);
                    nxt_r.st = ST_COMMIT;
                end else if (cmd_program || cmd_erase) begin
                    if (r_ff.pp[pblk_of(flash_addr_reg)]) begin // [RQ6]
                        t_start = 1'b1;
                        t_dur = cmd_erase ? UW'(ERASE_TIME_US)
                                          : UW'(PROG_TIME_US);
                        nxt_r.st = cmd_erase ? ST_ERASE : ST_PROG;
                    end else begin
                        acc_set = 1'b1; // [RQ11] [RQ6]
                    end
                end
            end
            ST_PROG: begin
                if (t_done) begin
                    prog_we = 1'b1; // [RQ3] [RQ16]
                    done_set = 1'b1;
                    nxt_r.st = ST_IDLE;
                end
            end
            ST_ERASE: begin
                if (t_done) begin
                    erase_we = 1'b1; // [RQ1] [RQ16]
                    done_set = 1'b1;
                    nxt_r.st = ST_IDLE;
                end
            end
            ST_COMMIT: begin
                if (t_done) begin
                    nvpp_we = r_ff.commit_pp; // [RQ15]
                    nvrp_we = !r_ff.commit_pp; // [RQ15]
                    done_set = 1'b1;
                    nxt_r.st = ST_IDLE;
                end
            end
            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase
        // an event in the clearing cycle keeps its flag
        if (acc_set) begin
            nxt_r.raw_acc = 1'b1;
        end else if (irq_clr_access) begin
            nxt_r.raw_acc = 1'b0; // [RQ20]
        end
        if (done_set) begin
            nxt_r.raw_done = 1'b1;
        end else if (irq_clr_done) begin
            nxt_r.raw_done = 1'b0; // [RQ20]
        end
        nxt_r.irq = nxt_r.raw_acc && access_fault_irq_mask; // [RQ11]
        nxt_r.busy = (nxt_r.st != ST_IDLE);
        nxt_r.cbusy = (nxt_r.st == ST_COMMIT); // [RQ22]
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r_ff <= '0;
            r_ff.st <= ST_LOAD;
            r_ff.pp <= flash_prot_pkg::PERMIT_RST;
            r_ff.rp <= flash_prot_pkg::PERMIT_RST;
            r_ff.reload <= flash_prot_pkg::USEC_RELOAD_RST; // [RQ17]
            r_ff.busy <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign block_program_permit_bits = r_ff.pp;
    assign block_read_permit_bits = r_ff.rp;
    assign microsecond_tick_reload = r_ff.reload;
    assign flash_busy = r_ff.busy;
    assign commit_busy = r_ff.cbusy;
    assign raw_access_irq = r_ff.raw_acc;
    assign raw_done_irq = r_ff.raw_done;
    assign access_irq = r_ff.irq;
    assign ifetch_valid = r_ff.ivalid;
    assign dread_valid = r_ff.dvalid;
    assign dread_fault = r_ff.dfault;

    // ****************************************************************
    // submodules
    // ****************************************************************
    usec_timer u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .reload(r_ff.reload),
        .start(t_start),
        .dur_us(t_dur),
        .done(t_done)
    );

    flash_nv_store u_store (
        .sys_clk(sys_clk),
        .factory_rst(nv_factory_rst),
        .iaddr(ifetch_addr[AW-1:2]),
        .irdata(ifetch_rdata),
        .daddr(dread_addr[AW-1:2]),
        .den(d_ok),
        .drdata(dread_rdata),
        .prog_we(prog_we),
        .erase_we(erase_we),
        .waddr(r_ff.widx),
        .wdata(r_ff.wdata),
        .pp_we(nvpp_we),
        .rp_we(nvrp_we),
        .permit_wdata(r_ff.commit_pp ? r_ff.pp : r_ff.rp),
        .nv_pp(nv_pp),
        .nv_rp(nv_rp)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_READ_FAULT: assert property ( // [RQ10]
        dread_req && !r_ff.rp[pblk_of(dread_addr)]
        |=> dread_fault && !dread_valid && dread_rdata == 32'h00000000)
        else $error("protected data read not faulted");
    AST_READ_OK: assert property ( // [RQ7]
        dread_req && r_ff.rp[pblk_of(dread_addr)]
        |=> dread_valid && !dread_fault)
        else $error("permitted data read not answered");
    AST_FETCH: assert property (ifetch_req |=> ifetch_valid) // [RQ9]
        else $error("instruction fetch not answered");
    AST_PP_CLEAR_ONLY: assert property ( // [RQ13]
        $past(r_ff.st) != ST_LOAD |-> (r_ff.pp & ~$past(r_ff.pp)) == '0)
        else $error("program permit bit set by write");
    AST_RP_CLEAR_ONLY: assert property ( // [RQ13]
        $past(r_ff.st) != ST_LOAD |-> (r_ff.rp & ~$past(r_ff.rp)) == '0)
        else $error("read permit bit set by write");
    AST_PROG_REFUSE: assert property ( // [RQ6]
        r_ff.st == ST_IDLE && !cmd_commit && (cmd_program || cmd_erase)
        && !r_ff.pp[pblk_of(flash_addr_reg)]
        |=> raw_access_irq && r_ff.st == ST_IDLE ##1 !prog_we [*2])
        else $error("change to program-protected block accepted");
    AST_IRQ_MASK: assert property ( // [RQ11]
        access_irq |-> raw_access_irq && $past(access_fault_irq_mask))
        else $error("access interrupt without raw flag and mask");
    AST_CLEAR: assert property ( // [RQ20]
        irq_clr_access && !acc_set |=> !raw_access_irq && !access_irq)
        else $error("access flag survived its clear");
    AST_RELOAD_RST: assert property ( // [RQ17]
        $past(rst) |-> microsecond_tick_reload
        == flash_prot_pkg::USEC_RELOAD_RST)
        else $error("reload not at reset value");
    AST_COMMIT_BUSY: assert property ( // [RQ22]
        (r_ff.st == ST_IDLE && cmd_commit)
        || (r_ff.st == ST_COMMIT && !t_done) |=> commit_busy)
        else $error("commit busy dropped early");
    AST_COMMIT_LIMIT: assert property ( // [RQ22]
        r_ff.st == ST_COMMIT && t_done |=> !commit_busy && raw_done_irq)
        else $error("commit busy stuck after store update");

    COV_PROG: cover property (prog_we);
    COV_FAULT: cover property (dread_fault);
    COV_COMMIT: cover property (nvpp_we || nvrp_we);
    COV_REFUSE: cover property (acc_set && access_fault_irq_mask);
endmodule // flash_block_protection_timing

/* File: pkg/flash_prot_pkg.sv */
// shared constants for the flash protection and timing controller
package flash_prot_pkg;
    // ****************************************************************
    // array geometry
    // ****************************************************************
    localparam int ADDR_W = 15;
    localparam int WIDX_W = 13;
    localparam int WORD_W = 32;
    localparam int UNIT_LSB = 10;
    localparam int UNIT_W = ADDR_W - UNIT_LSB;
    localparam int UNIT_WORDS = 256;
    localparam int PBLK_LSB = 11;
    localparam int PBLK_W = ADDR_W - PBLK_LSB;
    localparam int PERMIT_W = 32;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [PERMIT_W-1:0] PERMIT_RST = 32'hffffffff;
    localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffffffff;
    localparam logic [7:0] USEC_RELOAD_RST = 8'h31;
    // ****************************************************************
    // timing, in microseconds of the reload-derived tick
    // ****************************************************************
    localparam int US_W = 16;
    localparam int PROG_TIME_US = 20;
    localparam int ERASE_TIME_US = 20000;
    localparam int COMMIT_TIME_US = 20000;
endpackage

/* File: verilog/usec_timer.sv */
// microsecond tick and interval timer for flash pulses
`timescale 1ns/100ps
module usec_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reload,
    input wire logic start,
    input wire logic [flash_prot_pkg::US_W-1:0] dur_us,
    output logic done
);
    typedef struct packed {
        logic [7:0] pre;
        logic [flash_prot_pkg::US_W-1:0] left;
        logic run;
        logic done;
    } tmr_s;
    tmr_s r_ff;
    tmr_s nxt_r;

    assign done = r_ff.done;

    // ****************************************************************
    // prescaler counts reload+1 clocks per microsecond
    // ****************************************************************
    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        if (start) begin
            nxt_r.run = 1'b1;
            nxt_r.pre = reload;
            nxt_r.left = (dur_us == '0) ? 16'h0001 : dur_us;
        end else if (r_ff.run) begin
            if (r_ff.pre == 8'h00) begin
                nxt_r.pre = reload;
                if (r_ff.left == 16'h0001) begin
                    nxt_r.run = 1'b0;
                    nxt_r.done = 1'b1; // [RQ16]
                end
                nxt_r.left = r_ff.left - 16'h0001;
            end else begin
                nxt_r.pre = r_ff.pre - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_TMR_NO_EARLY: assert property (start |=> !done [*2]) // [RQ16]
        else $error("interval ended too soon after start");
endmodule // usec_timer

/* File: verilog/flash_nv_store.sv */
// flash word array and committed permit words
`timescale 1ns/100ps
module flash_nv_store (
    input wire logic sys_clk,
    input wire logic factory_rst,
    input wire logic [flash_prot_pkg::WIDX_W-1:0] iaddr,
    output logic [31:0] irdata,
    input wire logic [flash_prot_pkg::WIDX_W-1:0] daddr,
    input wire logic den,
    output logic [31:0] drdata,
    input wire logic prog_we,
    input wire logic erase_we,
    input wire logic [flash_prot_pkg::WIDX_W-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic pp_we,
    input wire logic rp_we,
    input wire logic [31:0] permit_wdata,
    output logic [31:0] nv_pp,
    output logic [31:0] nv_rp
);
    localparam int WORDS = 1 << flash_prot_pkg::WIDX_W;
    localparam int UW = flash_prot_pkg::UNIT_LSB - 2;
    localparam int WIDX_W_TOP = flash_prot_pkg::WIDX_W - 1;
    typedef struct packed {
        logic [31:0] pp;
        logic [31:0] rp;
    } nv_s;
    nv_s r_ff;
    nv_s nxt_r;
    logic [31:0] mem [WORDS];
    logic [31:0] irdata_ff;
    logic [31:0] drdata_ff;

    assign nv_pp = r_ff.pp;
    assign nv_rp = r_ff.rp;
    assign irdata = irdata_ff;
    assign drdata = drdata_ff;

    always_comb begin
        nxt_r = r_ff;
        if (pp_we) begin
            nxt_r.pp = r_ff.pp & permit_wdata; // [RQ15]
        end
        if (rp_we) begin
            nxt_r.rp = r_ff.rp & permit_wdata; // [RQ15]
        end
    end

    always_ff @(posedge sys_clk or posedge factory_rst) begin
        if (factory_rst) begin
            r_ff <= {flash_prot_pkg::PERMIT_RST, flash_prot_pkg::PERMIT_RST};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************************************
    // array: no reset, contents survive every reset like real cells
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        irdata_ff <= mem[iaddr];
        // refused reads return zero so protected data never leaves
        drdata_ff <= den ? mem[daddr] : 32'h00000000;
        if (erase_we) begin
            for (int i = 0; i < flash_prot_pkg::UNIT_WORDS; i++) begin
                mem[{waddr[WIDX_W_TOP:UW], UW'(i)}] <=
                    flash_prot_pkg::ERASED_WORD; // [RQ1] [RQ2]
            end
        end else if (prog_we) begin
            mem[waddr] <= mem[waddr] & wdata; // [RQ3]
        end
    end
endmodule // flash_nv_store

/* File: verif/cpu_bus_model.sv */
// processor fetch and data bus model facing the flash controller
`timescale 1ns/100ps
module cpu_bus_model (
    input wire logic sys_clk,
    input wire logic [31:0] ifetch_rdata,
    input wire logic ifetch_valid,
    input wire logic [31:0] dread_rdata,
    input wire logic dread_valid,
    input wire logic dread_fault,
    output logic ifetch_req,
    output logic [14:0] ifetch_addr,
    output logic dread_req,
    output logic [14:0] dread_addr
);
    initial begin
        ifetch_req = 1'b0;
        dread_req = 1'b0;
        ifetch_addr = 15'h7fff;
        dread_addr = 15'h7fff;
    end
    // one word per request; the address is inverted once released so a
    // design that samples it late picks up the wrong word
    task automatic rd(input logic fetch, input logic [14:0] a,
                      output logic [31:0] d, output logic [1:0] st);
        @(posedge sys_clk);
        if (fetch) begin
            ifetch_req <= 1'b1;
            ifetch_addr <= a;
        end else begin
            dread_req <= 1'b1;
            dread_addr <= a;
        end
        @(posedge sys_clk);
        ifetch_req <= 1'b0;
        dread_req <= 1'b0;
        ifetch_addr <= ~a;
        dread_addr <= ~a;
        #1;
        d = fetch ? ifetch_rdata : dread_rdata;
        st = fetch ? {ifetch_valid, 1'b0} : {dread_valid, dread_fault};
    endtask
endmodule // cpu_bus_model

/* File: verif/tb_top.sv */
// self-checking bench for the flash protection and timing controller
`timescale 1ns/100ps
module tb_top;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam int PROG_T = 2;
    localparam logic [31:0] ONES = flash_prot_pkg::PERMIT_RST;
    localparam logic [31:0] ERASED = flash_prot_pkg::ERASED_WORD;
    logic sys_clk, rst, nv_factory_rst, ifetch_req, ifetch_valid;
    logic dread_req, dread_valid, dread_fault, cmd_program, cmd_erase;
    logic cmd_commit, ppermit_wr, rpermit_wr, reload_wr, irq_clr_access;
    logic access_fault_irq_mask, irq_clr_done, flash_busy, commit_busy;
    logic raw_access_irq, raw_done_irq, access_irq, saw_cb;
    logic [14:0] ifetch_addr, dread_addr, flash_addr_reg;
    logic [31:0] ifetch_rdata, dread_rdata, flash_wdata, ppermit_wdata;
    logic [31:0] rpermit_wdata, block_program_permit_bits, rd_d;
    logic [31:0] block_read_permit_bits;
    logic [7:0] reload_wdata, microsecond_tick_reload;
    logic [1:0] rd_s;
    int error_cnt, n_tests, c1, c2;

    flash_block_protection_timing #(.PROG_TIME_US(PROG_T),
        .ERASE_TIME_US(3), .COMMIT_TIME_US(3)) DUT (.sys_clk, .rst,
        .nv_factory_rst, .ifetch_req, .ifetch_addr, .ifetch_rdata,
        .ifetch_valid, .dread_req, .dread_addr, .dread_rdata, .dread_valid,
        .dread_fault, .flash_addr_reg, .flash_wdata, .cmd_program,
        .cmd_erase, .cmd_commit, .ppermit_wr, .ppermit_wdata, .rpermit_wr,
        .rpermit_wdata, .reload_wr, .reload_wdata, .access_fault_irq_mask,
        .irq_clr_access, .irq_clr_done, .block_program_permit_bits,
        .block_read_permit_bits, .microsecond_tick_reload, .flash_busy,
        .commit_busy, .raw_access_irq, .raw_done_irq, .access_irq);

    cpu_bus_model cpu (.sys_clk, .ifetch_rdata, .ifetch_valid, .dread_rdata,
        .dread_valid, .dread_fault, .ifetch_req, .ifetch_addr, .dread_req,
        .dread_addr);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic set_reload(input logic [7:0] v);
        @(posedge sys_clk);
        reload_wr <= 1'b1;
        reload_wdata <= v;
        @(posedge sys_clk);
        reload_wr <= 1'b0;
        #1;
    endtask
    task automatic permit(input logic prog, input logic [31:0] v);
        @(posedge sys_clk);
        ppermit_wr <= prog;
        rpermit_wr <= ~prog;
        ppermit_wdata <= v;
        rpermit_wdata <= v;
        @(posedge sys_clk);
        ppermit_wr <= 1'b0;
        rpermit_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic clr_access();
        @(posedge sys_clk);
        irq_clr_access <= 1'b1;
        @(posedge sys_clk);
        irq_clr_access <= 1'b0;
        cyc(2);
    endtask
    task automatic do_rst();
        @(posedge sys_clk);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(3);
    endtask
    // k: 0 program, 1 erase, 2 commit; n counts cycles until a flag rises
    task automatic cmd(input int k, input logic [14:0] a,
                       input logic [31:0] d, output int n);
        n = 0;
        @(posedge sys_clk);
        flash_addr_reg <= a;
        flash_wdata <= d;
        cmd_program <= (k == 0);
        cmd_erase <= (k == 1);
        cmd_commit <= (k == 2);
        @(posedge sys_clk);
        cmd_program <= 1'b0;
        cmd_erase <= 1'b0;
        cmd_commit <= 1'b0;
        #1;
        while (raw_done_irq !== 1'b1 && raw_access_irq !== 1'b1 &&
               n < 3000) begin
            if (commit_busy === 1'b1)
                saw_cb = 1'b1;
            cyc(1);
            n++;
        end
        chk("completion", 32'h1, {31'h0, n < 3000});
        @(posedge sys_clk);
        irq_clr_done <= 1'b1;
        @(posedge sys_clk);
        irq_clr_done <= 1'b0;
        cyc(1);
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        {cmd_program, cmd_erase, cmd_commit, ppermit_wr, rpermit_wr} = '0;
        {reload_wr, irq_clr_access, irq_clr_done, saw_cb} = '0;
        access_fault_irq_mask = 1'b0;
        flash_addr_reg = 15'h0;
        flash_wdata = 32'h0;
        ppermit_wdata = 32'h0;
        rpermit_wdata = 32'h0;
        reload_wdata = 8'h0;
        error_cnt = 0;
        n_tests = 0;
        rst = 1'b1;
        nv_factory_rst = 1'b1;
        cyc(2);
        rst <= 1'b0;
        nv_factory_rst <= 1'b0;
        cyc(3);
        chk("pp_reset", ONES, block_program_permit_bits);
        chk("rp_reset", ONES, block_read_permit_bits);
        chk("reload_reset", {24'h0, flash_prot_pkg::USEC_RELOAD_RST},
            {24'h0, microsecond_tick_reload});
        set_reload(8'h01);
        chk("reload", 32'h1, {24'h0, microsecond_tick_reload});
        cmd(1, 15'h0000, 32'h0, c1);
        cmd(1, 15'h0400, 32'h0, c1);
        cmd(1, 15'h0800, 32'h0, c1);
        cmd(0, 15'h0404, 32'ha5a5ffff, c1);
        cmd(0, 15'h0404, 32'hffff0f0f, c1);
        cpu.rd(0, 15'h0404, rd_d, rd_s);
        chk("and_program", 32'ha5a50f0f, rd_d);
        chk("read_ok", 32'h2, {30'h0, rd_s});
        cmd(0, 15'h0008, 32'h12345678, c1);
        cmd(1, 15'h0000, 32'h0, c1);
        cpu.rd(0, 15'h0008, rd_d, rd_s);
        chk("erased", ERASED, rd_d);
        cpu.rd(0, 15'h0404, rd_d, rd_s);
        chk("unit_kept", 32'ha5a50f0f, rd_d);
        cmd(0, 15'h000c, 32'hfffffff0, c1);
        set_reload(8'h03);
        cmd(0, 15'h0010, 32'hfffffff0, c2);
        chk("usec_scaling", 32'(2 * PROG_T), 32'(c2 - c1));
        set_reload(8'h01);
        permit(0, 32'hfffffffe);
        chk("rp_clear", 32'hfffffffe, block_read_permit_bits);
        cpu.rd(0, 15'h0008, rd_d, rd_s);
        chk("xonly_data", 32'h0, rd_d);
        chk("xonly_fault", 32'h1, {30'h0, rd_s});
        cpu.rd(0, 15'h07fc, rd_d, rd_s);
        chk("pair_fault", 32'h1, {30'h0, rd_s});
        cpu.rd(0, 15'h0804, rd_d, rd_s);
        chk("next_block", ERASED, rd_d);
        chk("next_ok", 32'h2, {30'h0, rd_s});
        cmd(0, 15'h0008, 32'h0000ffff, c1);
        cpu.rd(1, 15'h0008, rd_d, rd_s);
        chk("xonly_fetch", 32'h0000ffff, rd_d);
        chk("fetch_ok", 32'h2, {30'h0, rd_s});
        permit(0, ONES);
        chk("no_set", 32'hfffffffe, block_read_permit_bits);
        permit(1, 32'hfffffffd);
        cmd(0, 15'h0804, 32'h0, c1);
        chk("refused_busy", 32'h0, {31'h0, flash_busy});
        chk("raw_access", 32'h1, {31'h0, raw_access_irq});
        chk("masked_off", 32'h0, {31'h0, access_irq});
        @(posedge sys_clk);
        access_fault_irq_mask <= 1'b1;
        cyc(2);
        chk("masked_on", 32'h1, {31'h0, access_irq});
        clr_access();
        chk("clr_raw", 32'h0, {31'h0, raw_access_irq});
        chk("clr_masked", 32'h0, {31'h0, access_irq});
        cmd(1, 15'h0c00, 32'h0, c1);
        chk("erase_refused", 32'h1, {31'h0, raw_access_irq});
        clr_access();
        cpu.rd(0, 15'h0804, rd_d, rd_s);
        chk("unchanged", ERASED, rd_d);
        do_rst();
        chk("pp_restored", ONES, block_program_permit_bits);
        chk("rp_restored", ONES, block_read_permit_bits);
        set_reload(8'h01);
        permit(1, 32'hfffffffb);
        permit(0, 32'hfffffff7);
        cmd(2, 15'h0001, 32'h0, c1);
        chk("commit_busy_seen", 32'h1, {31'h0, saw_cb});
        chk("commit_busy_end", 32'h0, {31'h0, commit_busy});
        cmd(2, 15'h0000, 32'h0, c1);
        do_rst();
        chk("pp_kept", 32'hfffffffb, block_program_permit_bits);
        chk("rp_kept", 32'hfffffff7, block_read_permit_bits);
        give_verdict();
    end

    initial begin
        cyc(20000);
        error_cnt++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        give_verdict();
    end
endmodule // tb_top
